// ---- logic/tsc_irq.sv ----
// Sticky interrupt status with write-one-to-clear and a mask of equal layout.
// Assumes events are one-cycle pulses from the same clock.
`timescale 1ns/1ps
module tsc_irq
    import tsc_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic [IRQ_W-1:0] evt,
    input  wire logic             wr_status,
    input  wire logic             wr_mask,
    input  wire logic [IRQ_W-1:0] wdata,
    output logic      [IRQ_W-1:0] status,
    output logic      [IRQ_W-1:0] mask,
    output logic                  irq
);

    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] status_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] mask_next;
    logic             irq_reg;
    logic             irq_next;

    always_comb begin
        status_next = status_reg;
        mask_next   = mask_reg;
        if (wr_status) begin
            status_next = status_reg & ~wdata;
        end
        // Event in the clearing cycle is kept
        status_next = status_next | evt;
        if (wr_mask) begin
            mask_next = wdata;
        end
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= '0;
            mask_reg   <= '0;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            irq_reg    <= irq_next;
        end
    end

    assign status = status_reg;
    assign mask   = mask_reg;
    assign irq    = irq_reg;

endmodule // tsc_irq

// ---- logic/tsc_pkg.sv ----
// Shared constants, types and register map of the trim sequence control block.
// Assumes one 250 MHz system clock and an 8-bit register port.
package tsc_pkg;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFS_TRIM_CONTROL_ONE = 8'h60;
    localparam logic [ADDR_W-1:0] OFS_TRIM_CONTROL_TWO = 8'h61;
    localparam logic [ADDR_W-1:0] OFS_RING_MISMATCH    = 8'h62;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS       = 8'h70;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK         = 8'h71;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned BIT_FULL_TRIM_RUN  = 6;
    localparam int unsigned BIT_SETTLE_SHORTEN = 5;
    localparam int unsigned STEP_FIELD_W       = 5;
    localparam int unsigned CTRL_ONE_W         = 6;
    localparam int unsigned RING_W             = 5;
    localparam int unsigned NUM_STEPS          = 10;
    localparam int unsigned STEP_RING_IDX      = 9;

    localparam logic [CTRL_ONE_W-1:0]   RST_TRIM_CONTROL_ONE = 6'h1F;
    localparam logic [STEP_FIELD_W-1:0] RST_TRIM_CONTROL_TWO = 5'h1F;
    localparam logic [RING_W-1:0]       RST_RING_MISMATCH    = 5'h10;
    localparam logic [2:0]              STANDALONE_MASK      = 3'h7;

    // ------------------------------------------------------------------
    // Interrupt layout
    // ------------------------------------------------------------------
    localparam int unsigned IRQ_W         = 2;
    localparam int unsigned IRQ_SEQ_DONE  = 0;
    localparam int unsigned IRQ_STEP_DONE = 1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W           = 24;
    localparam int unsigned MS_W            = 9;
    localparam int unsigned CLK_PERIOD_NS   = 4;
    localparam int unsigned MS_NS           = 1000000;
    localparam int unsigned SETTLE_LONG_MS  = 300;
    localparam int unsigned SETTLE_SHORT_MS = 30;
    localparam int unsigned STEP_TIME_NS    = 100000;
    localparam logic [CNT_W-1:0] TICK_CYCLES_DFLT = CNT_W'(MS_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] STEP_CYCLES_DFLT = CNT_W'(STEP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [MS_W-1:0]  SETTLE_LONG_LAST  = MS_W'(SETTLE_LONG_MS - 1);
    localparam logic [MS_W-1:0]  SETTLE_SHORT_LAST = MS_W'(SETTLE_SHORT_MS - 1);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TSC_IDLE   = 3'b001,
        TSC_SETTLE = 3'b010,
        TSC_STEP   = 3'b100
    } tsc_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tsc_bus_req_s;

endpackage

// ---- logic/tsc_tick_div.sv ----
// Millisecond enable divider for the settling wait.
// Assumes en stays high for the whole wait; dropping en restarts the count.
`timescale 1ns/1ps
module tsc_tick_div
    import tsc_pkg::*;
#(
    parameter logic [CNT_W-1:0] TICK_CYCLES = TICK_CYCLES_DFLT
) (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic en,
    output logic      tick
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             tick_reg;
    logic             tick_next;

    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!en) begin
            cnt_next = '0;
        end else if (cnt_reg == TICK_CYCLES - CNT_W'(1)) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule // tsc_tick_div

// ---- logic/tsc_top.sv ----
// Trim sequence control: registers, settling wait and step sequencer.
// Assumes a same-clock register port and a same-clock ring mismatch measurement.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module tsc_top
    import tsc_pkg::*;
#(
    parameter logic [CNT_W-1:0] TICK_CYCLES = TICK_CYCLES_DFLT,
    parameter logic [CNT_W-1:0] STEP_CYCLES = STEP_CYCLES_DFLT
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire tsc_bus_req_s         bus_req,
    input  wire logic [RING_W-1:0]    ring_meas,
    output logic      [DATA_W-1:0]    rdata,
    output logic      [NUM_STEPS-1:0] step_active,
    output logic                      settle_active,
    output logic                      irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tsc_state_e               state_reg;
    tsc_state_e               state_next;
    logic                     master_reg;
    logic                     master_next;
    logic [CTRL_ONE_W-1:0]    ctrl_one_reg;
    logic [CTRL_ONE_W-1:0]    ctrl_one_next;
    logic [STEP_FIELD_W-1:0]  ctrl_two_reg;
    logic [STEP_FIELD_W-1:0]  ctrl_two_next;
    logic [RING_W-1:0]        ring_reg;
    logic [RING_W-1:0]        ring_next;
    logic [NUM_STEPS-1:0]     run_mask_reg;
    logic [NUM_STEPS-1:0]     run_mask_next;
    logic [CNT_W-1:0]         step_cnt_reg;
    logic [CNT_W-1:0]         step_cnt_next;
    logic [MS_W-1:0]          ms_cnt_reg;
    logic [MS_W-1:0]          ms_cnt_next;
    logic [DATA_W-1:0]        rdata_reg;
    logic [DATA_W-1:0]        rdata_next;
    logic [NUM_STEPS-1:0]     step_active_reg;
    logic [NUM_STEPS-1:0]     step_active_next;
    logic                     settle_active_reg;
    logic                     settle_active_next;

    logic [NUM_STEPS-1:0]     cur_oh;
    logic [NUM_STEPS-1:0]     hw_clr;
    logic [IRQ_W-1:0]         evt;
    logic                     ring_capture;
    logic                     tick;
    logic [MS_W-1:0]          settle_last;
    logic [IRQ_W-1:0]         irq_status;
    logic [IRQ_W-1:0]         irq_mask;
    logic                     wr_one;
    logic                     wr_two;
    logic                     wr_ring;

    assign wr_one  = bus_req.wr && (bus_req.addr == OFS_TRIM_CONTROL_ONE);
    assign wr_two  = bus_req.wr && (bus_req.addr == OFS_TRIM_CONTROL_TWO);
    assign wr_ring = bus_req.wr && (bus_req.addr == OFS_RING_MISMATCH);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    tsc_tick_div #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .mclk   (mclk),
        .resetn (resetn),
        .en     (state_reg == TSC_SETTLE),
        .tick   (tick)
    );

    tsc_irq u_irq (
        .mclk      (mclk),
        .resetn    (resetn),
        .evt       (evt),
        .wr_status (bus_req.wr && (bus_req.addr == OFS_IRQ_STATUS)),
        .wr_mask   (bus_req.wr && (bus_req.addr == OFS_IRQ_MASK)),
        .wdata     (bus_req.wdata[IRQ_W-1:0]),
        .status    (irq_status),
        .mask      (irq_mask),
        .irq       (irq)
    );

    // Highest pending step runs first: ring, tip, diff, common, limit, then second group
    always_comb begin
        cur_oh = '0;
        for (int i = 0; i < NUM_STEPS; i++) begin
            if (run_mask_reg[i]) begin
                cur_oh = '0;
                cur_oh[i] = 1'b1;
            end
        end
    end

    // Settling time follows the live settle_shorten bit
    assign settle_last = ctrl_one_reg[BIT_SETTLE_SHORTEN] ? SETTLE_SHORT_LAST
                                                          : SETTLE_LONG_LAST;

    // ------------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        master_next   = master_reg;
        run_mask_next = run_mask_reg;
        step_cnt_next = step_cnt_reg;
        ms_cnt_next   = ms_cnt_reg;
        hw_clr        = '0;
        evt           = '0;
        ring_capture  = 1'b0;

        case (state_reg)
            TSC_IDLE: begin
                if (wr_one && bus_req.wdata[BIT_FULL_TRIM_RUN]) begin
                    master_next   = 1'b1;
                    run_mask_next = {bus_req.wdata[STEP_FIELD_W-1:0],
                                     ctrl_two_reg};
                    ms_cnt_next   = '0;
                    state_next    = TSC_SETTLE;
                end else if (wr_two && |(bus_req.wdata[2:0] & STANDALONE_MASK)) begin
                    // Only the three offset/balance steps start on their own
                    run_mask_next = {7'h00, bus_req.wdata[2:0]};
                    step_cnt_next = '0;
                    state_next    = TSC_STEP;
                end
            end
            TSC_SETTLE: begin
                if (tick) begin
                    if (ms_cnt_reg == settle_last) begin
                        step_cnt_next = '0;
                        if (run_mask_reg == '0) begin
                            master_next = 1'b0;
                            evt[IRQ_SEQ_DONE] = 1'b1;
                            state_next  = TSC_IDLE;
                        end else begin
                            state_next = TSC_STEP;
                        end
                    end else begin
                        ms_cnt_next = ms_cnt_reg + MS_W'(1);
                    end
                end
            end
            TSC_STEP: begin
                if (step_cnt_reg == STEP_CYCLES - CNT_W'(1)) begin
                    hw_clr        = cur_oh;
                    run_mask_next = run_mask_reg & ~cur_oh;
                    ring_capture  = cur_oh[STEP_RING_IDX];
                    step_cnt_next = '0;
                    if ((run_mask_reg & ~cur_oh) == '0) begin
                        state_next  = TSC_IDLE;
                        master_next = 1'b0;
                        evt[IRQ_SEQ_DONE]  = master_reg;
                        evt[IRQ_STEP_DONE] = !master_reg;
                    end
                end else begin
                    step_cnt_next = step_cnt_reg + CNT_W'(1);
                end
            end
            default: begin
                state_next  = TSC_IDLE;
                master_next = 1'b0;
            end
        endcase

        // Software write wins over the hardware clear in the same cycle
        if (wr_one) begin
            ctrl_one_next = bus_req.wdata[CTRL_ONE_W-1:0];
        end else begin
            ctrl_one_next = ctrl_one_reg & ~{1'b0, hw_clr[9:5]};
        end
        if (wr_two) begin
            ctrl_two_next = bus_req.wdata[STEP_FIELD_W-1:0];
        end else begin
            ctrl_two_next = ctrl_two_reg & ~hw_clr[4:0];
        end
        if (wr_ring) begin
            ring_next = bus_req.wdata[RING_W-1:0];
        end else if (ring_capture) begin
            ring_next = ring_meas;
        end else begin
            ring_next = ring_reg;
        end

        // Read data stand for one cycle only; unmapped reads return zero
        rdata_next = '0;
        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_TRIM_CONTROL_ONE: rdata_next = {1'b0, master_reg, ctrl_one_reg};
                OFS_TRIM_CONTROL_TWO: rdata_next = {3'h0, ctrl_two_reg};
                OFS_RING_MISMATCH:    rdata_next = {3'h0, ring_reg};
                OFS_IRQ_STATUS:       rdata_next = {6'h00, irq_status};
                OFS_IRQ_MASK:         rdata_next = {6'h00, irq_mask};
                default:              rdata_next = '0;
            endcase
        end

        step_active_next   = (state_reg == TSC_STEP) ? cur_oh : '0;
        settle_active_next = (state_reg == TSC_SETTLE);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg         <= TSC_IDLE;
            master_reg        <= 1'b0;
            ctrl_one_reg      <= RST_TRIM_CONTROL_ONE;
            ctrl_two_reg      <= RST_TRIM_CONTROL_TWO;
            ring_reg          <= RST_RING_MISMATCH;
            run_mask_reg      <= '0;
            step_cnt_reg      <= '0;
            ms_cnt_reg        <= '0;
            rdata_reg         <= '0;
            step_active_reg   <= '0;
            settle_active_reg <= 1'b0;
        end else begin
            state_reg         <= state_next;
            master_reg        <= master_next;
            ctrl_one_reg      <= ctrl_one_next;
            ctrl_two_reg      <= ctrl_two_next;
            ring_reg          <= ring_next;
            run_mask_reg      <= run_mask_next;
            step_cnt_reg      <= step_cnt_next;
            ms_cnt_reg        <= ms_cnt_next;
            rdata_reg         <= rdata_next;
            step_active_reg   <= step_active_next;
            settle_active_reg <= settle_active_next;
        end
    end

    assign rdata         = rdata_reg;
    assign step_active   = step_active_reg;
    assign settle_active = settle_active_reg;

endmodule // tsc_top

// ---- tb/tsc_props.sv ----
// Concurrent checks on the trim sequence control top-level ports.
// Assumes a single mclk domain and the bind at the foot of this file.
`timescale 1ns/1ps
module tsc_props
    import tsc_pkg::*;
#(
    parameter logic [CNT_W-1:0] TICK_CYCLES = TICK_CYCLES_DFLT,
    parameter logic [CNT_W-1:0] STEP_CYCLES = STEP_CYCLES_DFLT
) (
    input wire logic                 mclk,
    input wire logic                 resetn,
    input wire tsc_bus_req_s         bus_req,
    input wire logic [RING_W-1:0]    ring_meas,
    input wire logic [DATA_W-1:0]    rdata,
    input wire logic [NUM_STEPS-1:0] step_active,
    input wire logic                 settle_active,
    input wire logic                 irq
);
    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    logic [NUM_STEPS-1:0] prev_sa_reg;
    logic [31:0]          run_len_reg;
    logic [31:0]          settle_len_reg;
    logic                 step_chg;

    assign step_chg = (step_active != prev_sa_reg) && (prev_sa_reg != '0);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prev_sa_reg    <= '0;
            run_len_reg    <= 32'h0;
            settle_len_reg <= 32'h0;
        end else begin
            prev_sa_reg    <= step_active;
            run_len_reg    <= (step_active != prev_sa_reg) ? 32'h1 : run_len_reg + 32'h1;
            settle_len_reg <= settle_active ? settle_len_reg + 32'h1 : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Idle test excludes the cycle right after a write: outputs lag state
    sequence s_idle_start;
        bus_req.wr && bus_req.addr == OFS_TRIM_CONTROL_ONE
            && bus_req.wdata[BIT_FULL_TRIM_RUN] && !settle_active
            && step_active == '0 && !$past(bus_req.wr);
    endsequence
    sequence s_rd_of(a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    sequence s_ring_wr;
        bus_req.wr && bus_req.addr == OFS_RING_MISMATCH && step_active == '0 && !settle_active;
    endsequence

    property p_start;
        s_idle_start |-> ##[1:2] settle_active;
    endproperty
    property p_settle_len;
        settle_active |-> settle_len_reg < 32'(SETTLE_LONG_MS) * 32'(TICK_CYCLES) + 32'h2;
    endproperty
    property p_step_len;
        step_chg |-> run_len_reg == 32'(STEP_CYCLES);
    endproperty
    property p_order;
        step_chg && step_active != '0 |-> step_active < prev_sa_reg;
    endproperty
    property p_onehot;
        $onehot0(step_active) && !(settle_active && step_active != '0);
    endproperty
    property p_rd_idle;
        !$past(bus_req.rd) |-> rdata == '0;
    endproperty
    property p_ring_wr;
        s_ring_wr ##2 s_rd_of(OFS_RING_MISMATCH)
            |=> rdata == {3'h0, $past(bus_req.wdata[RING_W-1:0], 3)};
    endproperty
    property p_ctrl_read;
        s_rd_of(OFS_TRIM_CONTROL_TWO) |=> rdata[7:5] == 3'h0;
    endproperty

    a_start: assert property (p_start) else $error("full run did not start settling");
    a_settle_len: assert property (p_settle_len) else $error("settling wait too long");
    a_step_len: assert property (p_step_len) else $error("step length wrong");
    a_order: assert property (p_order) else $error("steps out of order");
    a_onehot: assert property (p_onehot) else $error("overlapping activity");
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    a_ring_wr: assert property (p_ring_wr) else $error("ring result readback wrong");
    a_ctrl_read: assert property (p_ctrl_read) else $error("reserved bits set");
endmodule // tsc_props

bind tsc_top tsc_props #(.TICK_CYCLES(TICK_CYCLES), .STEP_CYCLES(STEP_CYCLES)) tsc_props_i (
    .mclk(mclk), .resetn(resetn), .bus_req(bus_req), .ring_meas(ring_meas), .rdata(rdata),
    .step_active(step_active), .settle_active(settle_active), .irq(irq));

// ---- tb/tsc_top_tb.sv ----
// Self-checking bench for the trim sequence control block.
// Assumes shortened tick and step counts; drives the register port directly.
`timescale 1ns/1ps
module tsc_top_tb
    import tsc_pkg::*;
;
    localparam logic [CNT_W-1:0] TB_TICK = 24'h4;
    localparam logic [CNT_W-1:0] TB_STEP = 24'h8;
    localparam int               TICK_N  = 4;

    logic                 mclk;
    logic                 resetn;
    tsc_bus_req_s         bus_req;
    logic [RING_W-1:0]    ring_meas;
    logic [DATA_W-1:0]    rdata;
    logic [NUM_STEPS-1:0] step_active;
    logic                 settle_active;
    logic                 irq;
    int                   n_errors;
    int                   n_tests;

    tsc_top #(.TICK_CYCLES(TB_TICK), .STEP_CYCLES(TB_STEP)) tsc_top_i (
        .mclk(mclk), .resetn(resetn), .bus_req(bus_req), .ring_meas(ring_meas),
        .rdata(rdata), .step_active(step_active), .settle_active(settle_active), .irq(irq));

    always #2 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        if (seen !== exp) begin
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
            n_errors++;
        end
        n_tests++;
    endtask

    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk(16'(rdata), 16'(exp));
    endtask

    // Polls on the falling edge so registered outputs have settled
    task automatic wait_step(input logic [9:0] exp);
        int i;
        i = 0;
        while (step_active !== exp && i < 3000) begin
            @(negedge mclk);
            i++;
        end
        chk(16'(step_active), 16'(exp));
    endtask

    task automatic settle_len(input int exp);
        int n;
        n = 0;
        while (settle_active !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        while (settle_active === 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        chk(16'(n >= exp && n <= exp + 4), 16'h1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        bus_req = '0;
        ring_meas = 5'h15;
        n_errors = 0;
        n_tests = 0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        rd(OFS_TRIM_CONTROL_ONE, 8'h1F);
        rd(OFS_TRIM_CONTROL_TWO, 8'h1F);
        rd(OFS_RING_MISMATCH, 8'h10);
        rd(OFS_IRQ_STATUS, 8'h00);
        rd(8'h00, 8'h00);
        wr(OFS_RING_MISMATCH, 8'hEA);
        rd(OFS_RING_MISMATCH, 8'h0A);
        // Ring step enabled: bench stands for a discrete line interface
        wr(OFS_IRQ_MASK, 8'h01);
        wr(OFS_TRIM_CONTROL_ONE, 8'h7F);
        // Settling is timed from its first cycle, so the busy readback waits
        settle_len(int'(SETTLE_SHORT_MS) * TICK_N);
        rd(OFS_TRIM_CONTROL_ONE, 8'h7F);
        for (int k = 9; k >= 0; k--) wait_step(10'h001 << k);
        wait_step(10'h000);
        rd(OFS_TRIM_CONTROL_ONE, 8'h20);
        rd(OFS_TRIM_CONTROL_TWO, 8'h00);
        rd(OFS_RING_MISMATCH, 8'h15);
        chk(16'(irq), 16'h1);
        rd(OFS_IRQ_STATUS, 8'h01);
        wr(OFS_IRQ_STATUS, 8'h01);
        rd(OFS_IRQ_STATUS, 8'h00);
        chk(16'(irq), 16'h0);
        wr(OFS_TRIM_CONTROL_ONE, 8'h40);
        settle_len(int'(SETTLE_LONG_MS) * TICK_N);
        repeat (2) @(negedge mclk);
        rd(OFS_TRIM_CONTROL_ONE, 8'h00);
        chk(16'(irq), 16'h1);
        wr(OFS_IRQ_MASK, 8'h00);
        @(negedge mclk);
        chk(16'(irq), 16'h0);
        rd(OFS_IRQ_STATUS, 8'h01);
        wr(OFS_IRQ_STATUS, 8'h01);
        // Standalone runs skip the settling wait
        wr(OFS_IRQ_MASK, 8'h02);
        wr(OFS_TRIM_CONTROL_TWO, 8'h05);
        wait_step(10'h004);
        chk(16'(settle_active), 16'h0);
        wait_step(10'h001);
        rd(OFS_TRIM_CONTROL_TWO, 8'h01);
        wait_step(10'h000);
        wr(OFS_TRIM_CONTROL_TWO, 8'h02);
        wait_step(10'h002);
        wait_step(10'h000);
        rd(OFS_IRQ_STATUS, 8'h02);
        chk(16'(irq), 16'h1);
        stop_test();
    end

    initial begin
        #40000;
        n_errors++;
        stop_test();
    end
endmodule // tsc_top_tb
